// file: hw/burst_col_gen.sv
// Column sequencer for sequential and interleaved bursts
`timescale 1ns/100ps
`default_nettype none
module burst_col_gen (
    input wire logic [sdram_pkg::COL_W-1:0] start_i,
    input wire logic [sdram_pkg::COL_W-1:0] beat_i,
    input wire logic [2:0] bl_i,
    input wire logic ilv_i,
    output logic [sdram_pkg::COL_W-1:0] col_o
);
    import sdram_pkg::*;

    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] seq;

    assign mask = burst_mask(bl_i);
    assign seq = start_i + beat_i;
    // Carry out of the moving bits is masked off, so the burst wraps inside its block
    assign col_o = (start_i & ~mask) | ((ilv_i ? (start_i ^ beat_i) : seq) & mask);
endmodule
`default_nettype wire

// file: hw/sdram_cmd_burst.sv
// Command decode, bank state and burst engine of a four-bank synchronous DRAM
// Operation
// - Every pin is sampled only on rising clock edges.
// - Commands decode from current clock enable and its level one cycle earlier.
// - Access with A10 high auto-precharges the bank at burst end, except full-page bursts, which never do; low leaves it open.
// - Precharge with A10 high closes all banks, else the selected bank.
// - Read: column strobe low, row strobe and write enable high; address gives column.
// - Write: column strobe and write enable low, row strobe high; address gives column.
// - Data after the programmed write length is ignored.
// - Mode set is all four strobes low; address carries the mode word.
// - Reads and writes are accepted every cycle to any active bank.
// - Sequential or interleaved bursts of 1, 2, 4, 8 or full page.
// - Read interrupting read restarts full burst; old data drains meanwhile.
// - Write interrupting write continues at the new column for a full burst.
// - Read ends a write burst at once; remaining write data is dropped.
// - Burst stop ends a full-page burst and leaves the bank open.
// - After burst stop in a read, outputs float after the CAS latency.
// - Power-down request inside a burst becomes clock suspend.
// - Clock enable low suspends operation one clock later; resumes likewise.
// - Self refresh entry with banks idle; held while clock enable stays low.
`timescale 1ns/100ps
`default_nettype none
module sdram_cmd_burst (
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic CE_I,
    input wire logic CS_N_I,
    input wire logic RAS_N_I,
    input wire logic CAS_N_I,
    input wire logic WE_N_I,
    input wire logic CKE_I,
    input wire logic DQM_I,
    input wire logic [sdram_pkg::BANK_W-1:0] BANK_I,
    input wire logic [sdram_pkg::ROW_W-1:0] ADDR_I,
    input wire logic [sdram_pkg::DQ_W-1:0] DQ_I,
    input wire logic [sdram_pkg::DQ_W-1:0] ARRAY_RDATA_I,
    output logic [sdram_pkg::DQ_W-1:0] DQ_O,
    output logic DQ_OE_O,
    output logic ARRAY_RE_O,
    output logic ARRAY_WE_O,
    output logic [sdram_pkg::BANK_W-1:0] ARRAY_BANK_O,
    output logic [sdram_pkg::ROW_W-1:0] ARRAY_ROW_O,
    output logic [sdram_pkg::COL_W-1:0] ARRAY_COL_O,
    output logic [sdram_pkg::DQ_W-1:0] ARRAY_WDATA_O,
    output logic [sdram_pkg::NBANK-1:0] BANK_ACTIVE_O,
    output logic [sdram_pkg::ROW_W-1:0] MODE_O,
    output logic REFRESH_O,
    output logic SELF_REFRESH_O,
    output logic POWER_DOWN_O,
    output logic SUSPEND_O
);
    import sdram_pkg::*;

    // ==========================================================
    // Pin capture
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    logic [3:0] cmd;
    logic cke_s, dqm_s;
    logic [BANK_W-1:0] bank_s;
    logic [ROW_W-1:0] addr_s;
    logic [DQ_W-1:0] dq_s;
    logic cke_prev_r;

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            sync1_r <= {SYNC_W{1'b1}};
            sync2_r <= {SYNC_W{1'b1}};
            cke_prev_r <= 1'b1;
        end else if (CE_I) begin
            sync1_r <= {CS_N_I, RAS_N_I, CAS_N_I, WE_N_I, CKE_I, DQM_I, BANK_I, ADDR_I, DQ_I};
            sync2_r <= sync1_r;
            cke_prev_r <= cke_s;
        end
    end
    assign {cmd, cke_s, dqm_s, bank_s, addr_s, dq_s} = sync2_r;

    // ==========================================================
    // Command decode
    burst_state_t state_r;
    logic [NBANK-1:0] bank_act_r;
    logic [ROW_W-1:0] row_r [NBANK];
    logic [ROW_W-1:0] mode_r;
    logic [COL_W-1:0] start_r, cnt_r, col, beat_start, beat_idx, last;
    logic [BANK_W-1:0] bnk_r, acc_bank;
    logic ap_r, self_ref_r, run, cmd_ok, all_idle, page, last0, end_beat;
    logic cmd_act, cmd_pre, cmd_ref, cmd_sre, cmd_mrs, cmd_rd, cmd_wr, cmd_bst;
    logic new_acc, cont, beat_rd, beat_wr, burst_done;
    logic [PIPE_D-1:0] pv_r;
    logic [DQ_W-1:0] pd_r [PIPE_D];

    // Clock enable low one edge ago freezes burst, bank, mode and read-pipe state and drops the array strobes
    assign run = cke_prev_r;
    assign cmd_ok = cke_prev_r & ~self_ref_r;
    assign all_idle = (bank_act_r == 4'h0) && (state_r == ST_IDLE);
    assign cmd_act = cmd_ok && (cmd == CMD_ACT);
    assign cmd_pre = cmd_ok && (cmd == CMD_PRE);
    assign cmd_ref = cmd_ok && (cmd == CMD_REF) && cke_s;
    assign cmd_sre = cmd_ok && (cmd == CMD_REF) && !cke_s && all_idle;
    assign cmd_mrs = cmd_ok && (cmd == CMD_MRS) && all_idle;
    assign cmd_rd = cmd_ok && (cmd == CMD_RD) && bank_act_r[bank_s];
    assign cmd_wr = cmd_ok && (cmd == CMD_WR) && bank_act_r[bank_s];
    assign page = (mode_r[MR_BL_LSB+:3] == BL_PAGE);
    assign cmd_bst = cmd_ok && (cmd == CMD_BST) && (state_r != ST_IDLE) && page;

    // ==========================================================
    // Burst engine
    assign last = burst_mask(mode_r[MR_BL_LSB+:3]);
    assign last0 = (last == COL_ZERO);
    // A full-page burst wraps until stopped or interrupted
    assign end_beat = (cnt_r == last) && !page;
    assign new_acc = cmd_rd | cmd_wr;
    // Nop, deselect and other commands fall into cont and keep the burst going
    assign cont = (state_r != ST_IDLE) && !cmd_bst && !new_acc;
    assign beat_rd = cmd_rd | (cont && (state_r == ST_READ));
    assign beat_wr = cmd_wr | (cont && (state_r == ST_WRITE));
    assign beat_start = new_acc ? addr_s[COL_W-1:0] : start_r;
    assign beat_idx = new_acc ? COL_ZERO : cnt_r;
    assign acc_bank = new_acc ? bank_s : bnk_r;
    assign burst_done = (new_acc && last0 && addr_s[AP_BIT]) || (cont && end_beat && ap_r);

    burst_col_gen u_col (
        .start_i(beat_start),
        .beat_i(beat_idx),
        .bl_i(mode_r[MR_BL_LSB+:3]),
        .ilv_i(mode_r[MR_BT_BIT]),
        .col_o(col)
    );

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            state_r <= ST_IDLE;
            cnt_r <= COL_ZERO;
            start_r <= COL_ZERO;
            bnk_r <= 2'h0;
            ap_r <= 1'b0;
        end else if (CE_I && run) begin
            if (new_acc) begin
                // Any new access restarts from its own column, full length
                start_r <= addr_s[COL_W-1:0];
                bnk_r <= bank_s;
                ap_r <= addr_s[AP_BIT];
                cnt_r <= COL_ONE;
                if (last0) begin
                    state_r <= ST_IDLE;
                end else begin
                    state_r <= cmd_rd ? ST_READ : ST_WRITE;
                end
            end else if (cmd_bst) begin
                state_r <= ST_IDLE;
            end else if (state_r != ST_IDLE) begin
                cnt_r <= 9'(cnt_r + COL_ONE);
                if (end_beat) begin
                    state_r <= ST_IDLE;
                end
            end
        end
    end

    // ==========================================================
    // Array access
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            ARRAY_RE_O <= 1'b0;
            ARRAY_WE_O <= 1'b0;
            ARRAY_BANK_O <= 2'h0;
            ARRAY_ROW_O <= MODE_RST;
            ARRAY_COL_O <= COL_ZERO;
            ARRAY_WDATA_O <= 16'h0000;
        end else if (CE_I) begin
            ARRAY_RE_O <= run & beat_rd;
            ARRAY_WE_O <= run & beat_wr & ~dqm_s;
            if (run && (beat_rd || beat_wr)) begin
                ARRAY_BANK_O <= acc_bank;
                ARRAY_ROW_O <= row_r[acc_bank];
                ARRAY_COL_O <= col;
                ARRAY_WDATA_O <= dq_s;
            end
        end
    end

    // ==========================================================
    // Bank and mode state
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            bank_act_r <= 4'h0;
        end else if (CE_I && run) begin
            if (cmd_act) begin
                bank_act_r[bank_s] <= 1'b1;
            end
            if (cmd_pre && addr_s[AP_BIT]) begin
                bank_act_r <= 4'h0;
            end else if (cmd_pre) begin
                bank_act_r[bank_s] <= 1'b0;
            end
            if (burst_done) begin
                bank_act_r[acc_bank] <= 1'b0;
            end
        end
    end

    // Open rows are data, not control, so they carry no reset
    always_ff @(posedge CLK_I) begin
        if (CE_I && run && cmd_act) begin
            row_r[bank_s] <= addr_s;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            mode_r <= MODE_RST;
        end else if (CE_I && run && cmd_mrs) begin
            mode_r <= addr_s;
        end
    end

    // ==========================================================
    // Read data pipe and output drive
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            pv_r[0] <= 1'b0;
            pd_r[0] <= 16'h0000;
        end else if (CE_I && run) begin
            pv_r[0] <= ARRAY_RE_O;
            pd_r[0] <= ARRAY_RDATA_I;
        end
    end

    // Old beats keep draining after an interrupt or a stop
    for (genvar i = 1; i < PIPE_D; i++) begin : g_pipe
        always_ff @(posedge CLK_I) begin
            if (SRST_I) begin
                pv_r[i] <= 1'b0;
                pd_r[i] <= 16'h0000;
            end else if (CE_I && run) begin
                pv_r[i] <= pv_r[i-1];
                pd_r[i] <= pd_r[i-1];
            end
        end
    end

    logic cl_sel;
    assign cl_sel = (mode_r[MR_CL_LSB+:3] == CL_3);

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            DQ_O <= 16'h0000;
            DQ_OE_O <= 1'b0;
        end else if (CE_I && run) begin
            DQ_O <= pd_r[cl_sel];
            DQ_OE_O <= pv_r[cl_sel] & ~dqm_s;
        end
    end

    // ==========================================================
    // Power states
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            self_ref_r <= 1'b0;
            POWER_DOWN_O <= 1'b0;
            SUSPEND_O <= 1'b0;
            REFRESH_O <= 1'b0;
        end else if (CE_I) begin
            if (cmd_sre) begin
                self_ref_r <= 1'b1;
            end else if (cke_s) begin
                self_ref_r <= 1'b0;
            end
            // Banks open or data in flight turn a power-down request into suspend
            POWER_DOWN_O <= !cke_s && !cmd_sre && !self_ref_r && all_idle && (pv_r == '0);
            SUSPEND_O <= !cke_s && !(all_idle && (pv_r == '0));
            REFRESH_O <= cmd_ref;
        end
    end
    assign SELF_REFRESH_O = self_ref_r;
    assign BANK_ACTIVE_O = bank_act_r;
    assign MODE_O = mode_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I || !CE_I);

    sequence wr_cmd_s;
        cmd_wr && !dqm_s;
    endsequence
    sequence rd_stop_s;
        (cmd_bst && state_r == ST_READ) ##1 (!cmd_rd)[*4];
    endsequence

    act_opens_a: assert property (cmd_act && !burst_done |=> BANK_ACTIVE_O[$past(bank_s)])
        else $error("activate did not open bank");
    pre_all_a: assert property (cmd_pre && addr_s[AP_BIT] |=> BANK_ACTIVE_O == 4'h0)
        else $error("precharge all left a bank open");
    pre_one_a: assert property (cmd_pre && !addr_s[AP_BIT] && !cmd_act |=> !BANK_ACTIVE_O[$past(bank_s)])
        else $error("bank precharge did not close bank");
    mode_load_a: assert property (cmd_mrs |=> MODE_O == $past(addr_s))
        else $error("mode word not stored");
    wr_first_a: assert property (wr_cmd_s |=> ARRAY_WE_O && ARRAY_WDATA_O == $past(dq_s)
            && ARRAY_COL_O == $past(addr_s[COL_W-1:0]))
        else $error("first write beat wrong");
    rd_first_a: assert property (cmd_rd |=> ARRAY_RE_O && ARRAY_COL_O == $past(addr_s[COL_W-1:0]))
        else $error("first read beat wrong");
    wr_ignore_a: assert property (state_r == ST_IDLE && !cmd_wr |=> !ARRAY_WE_O)
        else $error("write outside a burst");
    suspend_hold_a: assert property (!cke_prev_r |=> $stable(cnt_r) && $stable(state_r) && !ARRAY_WE_O)
        else $error("state moved while suspended");
    cmd_gate_a: assert property (!cke_prev_r |=> $stable(BANK_ACTIVE_O) && $stable(MODE_O))
        else $error("command taken with clock enable low");
    nop_keep_a: assert property (state_r != ST_IDLE && cke_prev_r && cmd == CMD_NOP && !end_beat
            |=> state_r == $past(state_r) && cnt_r == 9'($past(cnt_r) + COL_ONE))
        else $error("no-operation disturbed burst");
    rd_cuts_wr_a: assert property (state_r == ST_WRITE && cmd_rd |=> !ARRAY_WE_O && ARRAY_RE_O)
        else $error("read did not end write burst");
    stop_end_a: assert property (cmd_bst |=> state_r == ST_IDLE)
        else $error("burst stop did not end burst");
    stop_float_a: assert property (rd_stop_s |=> !DQ_OE_O)
        else $error("outputs still driven after stop");
endmodule
`default_nettype wire

// file: hw/sdram_pkg.sv
// Constants, types and decode helpers shared by the DRAM command and burst logic
package sdram_pkg;
    // ==========================================================
    // Widths
    localparam int ROW_W = 13;
    localparam int COL_W = 9;
    localparam int DQ_W = 16;
    localparam int BANK_W = 2;
    localparam int NBANK = 4;
    localparam int PIPE_D = 2;
    localparam int SYNC_W = 4 + 1 + 1 + BANK_W + ROW_W + DQ_W;

    // ==========================================================
    // Command codes as {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_BST = 4'h6;
    localparam logic [3:0] CMD_NOP = 4'h7;

    // ==========================================================
    // Address bit and mode word fields
    localparam int AP_BIT = 10;
    localparam int MR_BL_LSB = 0;
    localparam int MR_BT_BIT = 3;
    localparam int MR_CL_LSB = 4;
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [2:0] CL_3 = 3'h3;
    localparam logic [ROW_W-1:0] MODE_RST = 13'h0000;
    localparam logic [COL_W-1:0] COL_ZERO = 9'h000;
    localparam logic [COL_W-1:0] COL_ONE = 9'h001;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b11
    } burst_state_t;

    // Bits of the column that move within one burst
    function automatic logic [COL_W-1:0] burst_mask(input logic [2:0] bl);
        case (bl)
            BL_1: burst_mask = 9'h000;
            BL_2: burst_mask = 9'h001;
            BL_4: burst_mask = 9'h003;
            BL_8: burst_mask = 9'h007;
            default: burst_mask = 9'h1ff;
        endcase
    endfunction
endpackage

// file: testbench/array_model.sv
// Behavioural storage array answering the block's beat strobes
`timescale 1ns/100ps
`default_nettype none
module array_model (
    input wire logic clk_i,
    input wire logic re_i,
    input wire logic we_i,
    input wire logic [1:0] bank_i,
    input wire logic [8:0] col_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] rdata_o
);
    // Row is ignored: one page per bank is enough here
    logic [15:0] mem [0:2047];
    logic [15:0] last_r;
    initial begin
        for (int i = 0; i < 2048; i++) begin
            mem[i] = 16'ha000 ^ 16'(i);
        end
        last_r = 16'h0000;
    end
    always @(posedge clk_i) begin
        if (we_i) mem[{bank_i, col_i}] <= wdata_i;
        if (re_i) last_r <= mem[{bank_i, col_i}];
    end
    // Inverse outside a beat, so a late sample never matches
    assign rdata_o = re_i ? mem[{bank_i, col_i}] : ~last_r;
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the DRAM command and burst logic
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import sdram_pkg::*;
    typedef logic [31:0] q_t[$];
    logic CLK_I, SRST_I, CE_I, CS_N_I, RAS_N_I, CAS_N_I, WE_N_I, CKE_I, DQM_I;
    logic [1:0] BANK_I, ARRAY_BANK_O;
    logic [12:0] ADDR_I, ARRAY_ROW_O, MODE_O;
    logic [15:0] DQ_I, ARRAY_RDATA_I, DQ_O, ARRAY_WDATA_O;
    logic [8:0] ARRAY_COL_O;
    logic [3:0] BANK_ACTIVE_O;
    logic DQ_OE_O, ARRAY_RE_O, ARRAY_WE_O, REFRESH_O, SELF_REFRESH_O, POWER_DOWN_O, SUSPEND_O;
    int n_mismatch = 0;
    int comparisons = 0;
    int nref = 0;
    int cyc = 0;
    q_t wq, rq, dq;

    sdram_cmd_burst u_dut (.CLK_I(CLK_I), .SRST_I(SRST_I), .CE_I(CE_I), .CS_N_I(CS_N_I),
        .RAS_N_I(RAS_N_I), .CAS_N_I(CAS_N_I), .WE_N_I(WE_N_I), .CKE_I(CKE_I), .DQM_I(DQM_I),
        .BANK_I(BANK_I), .ADDR_I(ADDR_I), .DQ_I(DQ_I), .ARRAY_RDATA_I(ARRAY_RDATA_I),
        .DQ_O(DQ_O), .DQ_OE_O(DQ_OE_O), .ARRAY_RE_O(ARRAY_RE_O), .ARRAY_WE_O(ARRAY_WE_O),
        .ARRAY_BANK_O(ARRAY_BANK_O), .ARRAY_ROW_O(ARRAY_ROW_O), .ARRAY_COL_O(ARRAY_COL_O),
        .ARRAY_WDATA_O(ARRAY_WDATA_O), .BANK_ACTIVE_O(BANK_ACTIVE_O), .MODE_O(MODE_O),
        .REFRESH_O(REFRESH_O), .SELF_REFRESH_O(SELF_REFRESH_O), .POWER_DOWN_O(POWER_DOWN_O),
        .SUSPEND_O(SUSPEND_O));
    array_model u_arr (.clk_i(CLK_I), .re_i(ARRAY_RE_O), .we_i(ARRAY_WE_O), .bank_i(ARRAY_BANK_O),
        .col_i(ARRAY_COL_O), .wdata_i(ARRAY_WDATA_O), .rdata_o(ARRAY_RDATA_I));

    initial begin
        CLK_I = 1'b0;
        forever #50 CLK_I = ~CLK_I;
    end

    // ==========================================================
    // Monitor and timeout
    always @(posedge CLK_I) begin
        cyc <= cyc + 1;
        if (ARRAY_WE_O === 1'b1) wq.push_back({5'h00, ARRAY_BANK_O, ARRAY_COL_O, ARRAY_WDATA_O});
        if (ARRAY_RE_O === 1'b1) rq.push_back({21'h0, ARRAY_BANK_O, ARRAY_COL_O});
        if (DQ_OE_O === 1'b1) dq.push_back({16'h0, DQ_O});
        if (REFRESH_O === 1'b1) nref++;
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    // ==========================================================
    // Helpers
    function automatic logic [31:0] wv(logic [1:0] b, logic [8:0] c, logic [15:0] d);
        return {5'h00, b, c, d};
    endfunction
    function automatic logic [31:0] rv(logic [1:0] b, logic [8:0] c);
        return {21'h0, b, c};
    endfunction
    function automatic logic [31:0] pv(logic [1:0] b, logic [8:0] c);
        return {16'h0, 16'ha000 ^ {5'h00, b, c}};
    endfunction
    task automatic end_sim();
        if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk(input string nm, input q_t e, input q_t g);
        cmp(nm, 32'(e.size()), 32'(g.size()));
        for (int i = 0; i < e.size() && i < g.size(); i++) cmp(nm, e[i], g[i]);
    endtask
    task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
                       input logic [15:0] d);
        @(posedge CLK_I);
        #1;
        {CS_N_I, RAS_N_I, CAS_N_I, WE_N_I} = c;
        BANK_I = b;
        ADDR_I = a;
        DQ_I = d;
    endtask
    // Released data bus toggles rather than holding the last word
    task automatic nop(input int n);
        cmd(CMD_NOP, 2'h0, 13'h0000, 16'(~cyc));
        repeat (n) @(posedge CLK_I);
        #1;
    endtask
    task automatic cke(input logic v);
        @(posedge CLK_I);
        #1;
        CKE_I = v;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_init();
        cmp("active", 32'h0, {28'h0, BANK_ACTIVE_O});
        DQM_I = 1'b1;
        nop(2000);
        DQM_I = 1'b0;
        cmd(CMD_PRE, 2'h0, 13'h0400, 16'h0);
        nref = 0;
        repeat (8) begin
            cmd(CMD_REF, 2'h0, 13'h0, 16'h0);
            nop(2);
        end
        cmd(CMD_MRS, 2'h0, 13'h0022, 16'h0);
        nop(6);
        cmp("refresh", 32'd8, nref);
        cmp("mode", 32'h22, {19'h0, MODE_O});
    endtask
    task automatic t_act();
        cmd(CMD_ACT, 2'h1, 13'h0123, 16'h0);
        cmd(CMD_ACT, 2'h2, 13'h0456, 16'h0);
        nop(4);
        cmp("active", 32'h6, {28'h0, BANK_ACTIVE_O});
    endtask
    task automatic t_wr();
        q_t e;
        wq.delete();
        cmd(CMD_WR, 2'h1, 13'h0002, 16'h1111);
        cmd(CMD_NOP, 2'h0, 13'h0, 16'h2222);
        cmd(CMD_NOP, 2'h0, 13'h0, 16'h3333);
        cmd(CMD_NOP, 2'h0, 13'h0, 16'h4444);
        cmd(CMD_NOP, 2'h0, 13'h0, 16'hdead);
        nop(8);
        e = {wv(1, 2, 16'h1111), wv(1, 3, 16'h2222), wv(1, 0, 16'h3333), wv(1, 1, 16'h4444)};
        chk("wr", e, wq);
    endtask
    task automatic t_rd();
        q_t e;
        rq.delete();
        dq.delete();
        cmd(CMD_RD, 2'h1, 13'h0002, 16'h0);
        nop(10);
        e = {rv(1, 2), rv(1, 3), rv(1, 0), rv(1, 1)};
        chk("rd col", e, rq);
        e = {32'h1111, 32'h2222, 32'h3333, 32'h4444};
        chk("rd data", e, dq);
        cmp("row", 32'h123, {19'h0, ARRAY_ROW_O});
    endtask
    task automatic t_rr();
        q_t e;
        q_t d;
        rq.delete();
        dq.delete();
        cmd(CMD_RD, 2'h2, 13'h0000, 16'h0);
        cmd(CMD_RD, 2'h2, 13'h0004, 16'h0);
        nop(10);
        e = {rv(2, 0), rv(2, 4), rv(2, 5), rv(2, 6), rv(2, 7)};
        d = {pv(2, 0), pv(2, 4), pv(2, 5), pv(2, 6), pv(2, 7)};
        chk("rr col", e, rq);
        chk("rr data", d, dq);
    endtask
    task automatic t_wi();
        q_t e;
        wq.delete();
        rq.delete();
        cmd(CMD_WR, 2'h2, 13'h0008, 16'h5a5a);
        cmd(CMD_RD, 2'h2, 13'h000c, 16'h0);
        nop(10);
        e = {wv(2, 8, 16'h5a5a)};
        chk("wi wr", e, wq);
        e = {rv(2, 12), rv(2, 13), rv(2, 14), rv(2, 15)};
        chk("wi rd", e, rq);
    endtask
    task automatic t_ww();
        q_t e;
        wq.delete();
        cmd(CMD_WR, 2'h1, 13'h0000, 16'hb000);
        cmd(CMD_WR, 2'h1, 13'h0005, 16'hc000);
        cmd(CMD_NOP, 2'h0, 13'h0, 16'hc001);
        cmd(CMD_NOP, 2'h0, 13'h0, 16'hc002);
        cmd(CMD_NOP, 2'h0, 13'h0, 16'hc003);
        nop(8);
        e = {wv(1, 0, 16'hb000), wv(1, 5, 16'hc000), wv(1, 6, 16'hc001), wv(1, 7, 16'hc002),
             wv(1, 4, 16'hc003)};
        chk("ww", e, wq);
    endtask
    task automatic t_dqm();
        rq.delete();
        dq.delete();
        DQM_I = 1'b1;
        cmd(CMD_RD, 2'h2, 13'h0000, 16'h0);
        nop(10);
        DQM_I = 1'b0;
        cmp("dqm beats", 32'd4, 32'(rq.size()));
        cmp("dqm drive", 32'd0, 32'(dq.size()));
    endtask
    task automatic t_ilv();
        q_t e;
        cmd(CMD_PRE, 2'h1, 13'h0000, 16'h0);
        nop(3);
        cmp("pre one", 32'h4, {28'h0, BANK_ACTIVE_O});
        cmd(CMD_PRE, 2'h0, 13'h0400, 16'h0);
        nop(3);
        cmp("pre all", 32'h0, {28'h0, BANK_ACTIVE_O});
        cmd(CMD_MRS, 2'h0, 13'h003b, 16'h0);
        cmd(CMD_ACT, 2'h2, 13'h0456, 16'h0);
        nop(3);
        rq.delete();
        dq.delete();
        cmd(CMD_RD, 2'h2, 13'h0003, 16'h0);
        nop(14);
        for (int k = 0; k < 8; k++) e.push_back(rv(2, 9'(3 ^ k)));
        chk("ilv", e, rq);
        cmp("ilv data", 32'd8, 32'(dq.size()));
        cmd(CMD_RD, 2'h2, 13'h0400, 16'h0);
        nop(14);
        cmp("auto pre", 32'h0, {28'h0, BANK_ACTIVE_O});
    endtask
    task automatic t_bst();
        q_t e;
        cmd(CMD_PRE, 2'h0, 13'h0400, 16'h0);
        cmd(CMD_MRS, 2'h0, 13'h0027, 16'h0);
        cmd(CMD_ACT, 2'h2, 13'h0456, 16'h0);
        nop(3);
        rq.delete();
        dq.delete();
        cmd(CMD_RD, 2'h2, 13'h0000, 16'h0);
        nop(1);
        cmd(CMD_BST, 2'h0, 13'h0, 16'h0);
        nop(8);
        e = {rv(2, 0), rv(2, 1), rv(2, 2)};
        chk("bst", e, rq);
        cmp("bst data", 32'd3, 32'(dq.size()));
        cmp("bst open", 32'h4, {28'h0, BANK_ACTIVE_O});
    endtask
    task automatic t_pwr();
        logic [8:0] c;
        cmd(CMD_RD, 2'h2, 13'h0000, 16'h0);
        nop(4);
        cke(1'b0);
        repeat (4) @(posedge CLK_I);
        #1;
        c = ARRAY_COL_O;
        repeat (3) @(posedge CLK_I);
        #1;
        cmp("suspend", 32'h1, {31'h0, SUSPEND_O});
        cmp("col held", {23'h0, c}, {23'h0, ARRAY_COL_O});
        cke(1'b1);
        nop(3);
        cmp("resume", 32'h0, {31'h0, SUSPEND_O});
        cmd(CMD_BST, 2'h0, 13'h0, 16'h0);
        cmd(CMD_PRE, 2'h0, 13'h0400, 16'h0);
        nop(6);
        cke(1'b0);
        repeat (5) @(posedge CLK_I);
        #1;
        cmp("powerdown", 32'h1, {31'h0, POWER_DOWN_O});
        cke(1'b1);
        nop(5);
        cmd(CMD_REF, 2'h0, 13'h0, 16'h0);
        CKE_I = 1'b0;
        nop(5);
        cmp("selfref", 32'h1, {31'h0, SELF_REFRESH_O});
        cke(1'b1);
        nop(5);
        cmp("selfref exit", 32'h0, {31'h0, SELF_REFRESH_O});
    endtask

    initial begin
        {CS_N_I, RAS_N_I, CAS_N_I, WE_N_I} = CMD_NOP;
        CE_I = 1'b1;
        CKE_I = 1'b1;
        DQM_I = 1'b0;
        BANK_I = 2'h0;
        ADDR_I = 13'h0000;
        DQ_I = 16'h0000;
        SRST_I = 1'b1;
        repeat (6) @(posedge CLK_I);
        #1;
        SRST_I = 1'b0;
        t_init();
        t_act();
        t_wr();
        t_rd();
        t_rr();
        t_wi();
        t_ww();
        t_dqm();
        t_ilv();
        t_bst();
        t_pwr();
        end_sim();
    end
endmodule
`default_nettype wire
